// *** switch_control_serial_port.sv ***
// Serial slave port, wake/watchdog and pin logic of a dual high-side switch
// Notes on behaviour
// - Sync output goes low while an on channel's current sense value is valid.
// - Sync output rises at every channel turn-off instant.
// - Direct input high turns channel on; low leaves it to register control in normal mode.
// - Rising direct input wakes device from sleep.
// - Load select low chooses bulb profile, high chooses motor profile.
// - Fault flag low while any listed fault is present.
// - Each fault sets own status bit; reading status clears it.
// - External PWM clock drives PWM; its loss is a fault.
// - Wake/reset low holds all serial registers at reset value.
// - Reset low and inputs idle past timeout puts device to sleep.
// - Wake/reset rising starts watchdog on first frame bit.
// - Port active and output driven only while chip select low.
// - Chip select rising stores frame into addressed register.
// - Chip select falling loads output shifter from one of eight sources.
// - Input sampled on falling serial clock, output changes on rising.
// - Frames are 16 bits, most significant bit first.
// - Register address taken from frame bits 9 to 12.
// - Output carries a readable register or the previous input frame.
// - Fail-safe flag low on lost communication or logic supply.
// - Without logic supply the output shifter is not readable.
// - PWM up to 1 kHz from internal or external clock, register chosen.
// - Direct input idle over 250 ms drops its activity signal.
module switch_control_serial_port
  import switch_ctrl_pkg::*;
#(
  parameter int WDT_COUNT  = WDT_CYCLES,
  parameter int IN_TIMEOUT = IN_TIMEOUT_CYCLES,
  parameter int CLK_LOSS   = CLK_LOSS_CYCLES,
  parameter int PWM_DIV    = 20000
) (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  input  wire logic                  sclk,
  input  wire logic                  chip_select_n,
  input  wire logic                  serial_in,
  output logic                       serial_out,
  output logic                       serial_out_oe_n,
  input  wire logic                  wake_reset_n,
  input  wire logic [1:0]            direct_in,
  input  wire logic [1:0]            load_profile_select,
  input  wire logic                  pwm_clock_in,
  input  wire logic                  logic_supply_ok,
  input  wire logic [FAULT_BITS-1:0] fault_events,
  input  wire logic [1:0]            sense_valid,
  output logic [1:0]                 channel_on,
  output logic [1:0]                 motor_profile,
  output logic                       fault_flag_n,
  output logic                       failsafe_flag_n,
  output logic                       sense_sync_n,
  output logic                       device_awake
);
  import switch_ctrl_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic sclk_r, sclk_f, cs_l, cs_r, cs_f, si_l, rst_l, rst_r, pclk_r;
  logic [1:0] din_l, din_r, cfg_l;

  sync_edge u_sclk (.clk(clk), .reset_n(reset_n), .async_in(sclk), .level(), .rise(sclk_r), .fall(sclk_f));
  // Idle-high pins start high so no false edge follows reset
  sync_edge #(.IDLE_LEVEL(1'b1)) u_cs (.clk(clk), .reset_n(reset_n), .async_in(chip_select_n), .level(cs_l),
                                      .rise(cs_r), .fall(cs_f));
  sync_edge u_si   (.clk(clk), .reset_n(reset_n), .async_in(serial_in), .level(si_l), .rise(), .fall());
  sync_edge u_rst  (.clk(clk), .reset_n(reset_n), .async_in(wake_reset_n), .level(rst_l), .rise(rst_r), .fall());
  sync_edge u_pclk (.clk(clk), .reset_n(reset_n), .async_in(pwm_clock_in), .level(), .rise(pclk_r), .fall());

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pins
      sync_edge u_din (.clk(clk), .reset_n(reset_n), .async_in(direct_in[g]), .level(din_l[g]),
                       .rise(din_r[g]), .fall());
      sync_edge #(.IDLE_LEVEL(1'b1)) u_cfg (.clk(clk), .reset_n(reset_n), .async_in(load_profile_select[g]),
                                           .level(cfg_l[g]), .rise(), .fall());
    end
  endgenerate

  // ----------------------------------------
  // Serial port state
  // ----------------------------------------
  logic [15:0] regs_q [NUM_REGS];
  logic [15:0] regs_d [NUM_REGS];
  logic [15:0] sh_in_q, sh_in_d, sh_out_q, sh_out_d, prev_frame_q, prev_frame_d;
  logic [4:0]  bit_cnt_q, bit_cnt_d;
  logic        so_q, so_d, oe_n_q, oe_n_d;
  logic [FAULT_BITS-1:0] fault_q, fault_d;
  logic        read_status;

  function automatic logic [15:0] read_source(input logic [2:0] sel, input logic [15:0] echo,
                                              input logic [FAULT_BITS-1:0] flt, input logic [15:0] r);
    logic [15:0] v;
    v = r;
    if (sel == SEL_ECHO)
      v = echo;
    else if (sel == ADDR_STATUS[2:0])
      v = {{(16-FAULT_BITS){1'b0}}, flt};
    return v;
  endfunction

  always_comb begin
    regs_d       = regs_q;
    sh_in_d      = sh_in_q;
    sh_out_d     = sh_out_q;
    prev_frame_d = prev_frame_q;
    bit_cnt_d    = bit_cnt_q;
    so_d         = so_q;
    oe_n_d       = oe_n_q;
    read_status  = 1'b0;
    if (!rst_l) begin
      for (int i = 0; i < NUM_REGS; i++) regs_d[i] = REG_RESET;
    end
    if (cs_f) begin
      oe_n_d    = ~logic_supply_ok;
      bit_cnt_d = '0;
      // Selected by the last frame's low address bits
      sh_out_d  = read_source(prev_frame_q[ADDR_LSB +: 3], prev_frame_q, fault_q,
                              regs_q[prev_frame_q[ADDR_LSB +: 3]]);
      read_status = (prev_frame_q[ADDR_LSB +: 3] == ADDR_STATUS[2:0]);
      so_d      = sh_out_d[FRAME_BITS-1];
    end else if (!cs_l) begin
      if (sclk_f) begin
        sh_in_d   = {sh_in_q[14:0], si_l};
        bit_cnt_d = bit_cnt_q + 5'd1;
      end
      if (sclk_r && bit_cnt_q != 5'd0) begin
        sh_out_d = {sh_out_q[14:0], 1'b0};
        so_d     = sh_out_q[14];
      end
    end
    if (cs_r) begin
      oe_n_d = 1'b1;
      if (bit_cnt_q == 5'(FRAME_BITS) && rst_l) begin
        regs_d[sh_in_q[ADDR_LSB +: ADDR_BITS]] = sh_in_q;
        prev_frame_d = sh_in_q;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < NUM_REGS; i++) regs_q[i] <= REG_RESET;
      sh_in_q      <= 16'h0000;
      sh_out_q     <= 16'h0000;
      prev_frame_q <= 16'h0000;
      bit_cnt_q    <= 5'h00;
      so_q         <= 1'b0;
      oe_n_q       <= 1'b1;
    end else begin
      regs_q       <= regs_d;
      sh_in_q      <= sh_in_d;
      sh_out_q     <= sh_out_d;
      prev_frame_q <= prev_frame_d;
      bit_cnt_q    <= bit_cnt_d;
      so_q         <= so_d;
      oe_n_q       <= oe_n_d;
    end
  end

  // ----------------------------------------
  // Faults, watchdog, activity, mode
  // ----------------------------------------
  logic [31:0] wdt_q, wdt_d, clk_loss_q, clk_loss_d;
  logic [31:0] act_q [2];
  logic [31:0] act_d [2];
  logic [1:0]  in_on_q, in_on_d;
  logic        wd_run_q, wd_run_d, wd_bit_q, wd_bit_d, wd_exp_q, wd_exp_d;
  logic        ext_sel, clk_fail;
  dev_mode_t   mode_q, mode_d;
  logic [FAULT_BITS-1:0] live_fault;
  logic        frame_done;

  assign ext_sel    = regs_q[ADDR_CONFIG][0];
  assign clk_fail   = ext_sel && clk_loss_q >= 32'(CLK_LOSS);
  assign live_fault = {fault_events[FAULT_BITS-1:7], clk_fail, fault_events[5:0]};
  assign frame_done = cs_r && bit_cnt_q == 5'(FRAME_BITS);

  always_comb begin
    // New events win over the clearing read
    fault_d = (read_status ? '0 : fault_q) | live_fault;
    clk_loss_d = pclk_r ? 32'd0 : (clk_loss_q >= 32'(CLK_LOSS) ? clk_loss_q : clk_loss_q + 32'd1);
    wd_run_d = wd_run_q;
    wd_bit_d = wd_bit_q;
    wd_exp_d = wd_exp_q;
    wdt_d    = wdt_q;
    if (!rst_l) begin
      wd_run_d = 1'b0;
      wd_exp_d = 1'b0;
    end else if (rst_r) begin
      wd_run_d = 1'b1;
      wdt_d    = '0;
    end else if (wd_run_q) begin
      if (frame_done && sh_in_q[WD_BIT_POS] != wd_bit_q) begin
        wd_bit_d = sh_in_q[WD_BIT_POS];
        wdt_d    = '0;
      end else if (wdt_q >= 32'(WDT_COUNT)) begin
        wd_exp_d = ~regs_q[ADDR_CONFIG][WD_OFF_BIT_POS];
      end else begin
        wdt_d = wdt_q + 32'd1;
      end
    end
    for (int c = 0; c < 2; c++) begin
      act_d[c]   = act_q[c];
      in_on_d[c] = in_on_q[c];
      if (din_r[c] || din_l[c]) begin
        act_d[c]   = '0;
        in_on_d[c] = 1'b1;
      end else if (act_q[c] >= 32'(IN_TIMEOUT)) begin
        in_on_d[c] = 1'b0;
      end else begin
        act_d[c] = act_q[c] + 32'd1;
      end
    end
    mode_d = mode_q;
    unique case (mode_q)
      MODE_SLEEP:    if (rst_r || |din_r) mode_d = MODE_NORMAL;
      MODE_NORMAL:   if (!rst_l && in_on_q == 2'b00) mode_d = MODE_SLEEP;
                     else if (wd_exp_q || (rst_l && !logic_supply_ok)) mode_d = MODE_FAILSAFE;
      MODE_FAILSAFE: if (!rst_l && in_on_q == 2'b00) mode_d = MODE_SLEEP;
                     else if (rst_r) mode_d = MODE_NORMAL;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      fault_q    <= '0;
      clk_loss_q <= 32'h0000_0000;
      wd_run_q   <= 1'b0;
      wd_bit_q   <= 1'b0;
      wd_exp_q   <= 1'b0;
      wdt_q      <= 32'h0000_0000;
      act_q[0]   <= 32'h0000_0000;
      act_q[1]   <= 32'h0000_0000;
      in_on_q    <= 2'b00;
      mode_q     <= MODE_SLEEP;
    end else begin
      fault_q    <= fault_d;
      clk_loss_q <= clk_loss_d;
      wd_run_q   <= wd_run_d;
      wd_bit_q   <= wd_bit_d;
      wd_exp_q   <= wd_exp_d;
      wdt_q      <= wdt_d;
      act_q      <= act_d;
      in_on_q    <= in_on_d;
      mode_q     <= mode_d;
    end
  end

  // ----------------------------------------
  // Channel control and flags
  // ----------------------------------------
  logic [31:0] pwm_cnt_q, pwm_cnt_d;
  logic        int_tick;
  logic [1:0]  pwm_ph_q, pwm_ph_d, on_q, on_d, prof_q, prof_d;
  logic        ff_q, ff_d, fs_q, fs_d, sync_q, sync_d, awake_q, awake_d;

  // Internal tick kept slow so PWM stays within 1 kHz
  assign int_tick = pwm_cnt_q >= 32'(PWM_DIV - 1);

  always_comb begin
    pwm_cnt_d = int_tick ? 32'd0 : pwm_cnt_q + 32'd1;
    pwm_ph_d  = pwm_ph_q;
    for (int c = 0; c < 2; c++) begin
      if (ext_sel ? pclk_r : int_tick) pwm_ph_d[c] = ~pwm_ph_q[c];
      on_d[c] = (mode_q != MODE_SLEEP) &&
                (din_l[c] || (mode_q == MODE_NORMAL && regs_q[ADDR_CONFIG][1+c] &&
                 (!regs_q[ADDR_CONFIG][3+c] || pwm_ph_q[c])));
    end
    prof_d  = cfg_l;
    ff_d    = ~(|fault_q | |live_fault);
    fs_d    = ~(mode_q == MODE_FAILSAFE || (rst_l && !logic_supply_ok));
    // Turn-off forces a rising edge even if sense still looked valid
    if (|(on_q & ~on_d))
      sync_d = 1'b1;
    else
      sync_d = ~(|(sense_valid & on_q));
    awake_d = mode_q != MODE_SLEEP;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pwm_cnt_q <= 32'h0000_0000;
      pwm_ph_q  <= 2'b00;
      on_q      <= 2'b00;
      prof_q    <= 2'b11;
      ff_q      <= 1'b1;
      fs_q      <= 1'b1;
      sync_q    <= 1'b1;
      awake_q   <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_d;
      pwm_ph_q  <= pwm_ph_d;
      on_q      <= on_d;
      prof_q    <= prof_d;
      ff_q      <= ff_d;
      fs_q      <= fs_d;
      sync_q    <= sync_d;
      awake_q   <= awake_d;
    end
  end

  assign serial_out      = so_q;
  assign serial_out_oe_n = oe_n_q;
  assign channel_on      = on_q;
  assign motor_profile   = prof_q;
  assign fault_flag_n    = ff_q;
  assign failsafe_flag_n = fs_q;
  assign sense_sync_n    = sync_q;
  assign device_awake    = awake_q;
endmodule

// *** switch_ctrl_pkg.sv ***
// Shared constants for the switch control serial port
package switch_ctrl_pkg;
  localparam int CLK_HZ            = 20_000_000;
  localparam int FRAME_BITS        = 16;
  localparam int ADDR_LSB          = 9;
  localparam int ADDR_BITS         = 4;
  localparam int WD_BIT_POS        = 15;
  localparam int WD_OFF_BIT_POS    = 8;
  localparam int WDT_MS            = 310;
  localparam int IN_TIMEOUT_MS     = 250;
  localparam int WDT_CYCLES        = CLK_HZ / 1000 * WDT_MS;
  localparam int IN_TIMEOUT_CYCLES = CLK_HZ / 1000 * IN_TIMEOUT_MS;
  localparam int CLK_LOSS_CYCLES   = 4096;
  localparam int NUM_REGS          = 16;
  localparam int NUM_READ_SEL      = 8;
  localparam int FAULT_BITS        = 9;
  localparam logic [15:0] REG_RESET = 16'h0000;
  localparam logic [3:0]  ADDR_STATUS = 4'h0;
  localparam logic [3:0]  ADDR_CONFIG = 4'h1;
  localparam logic [2:0]  SEL_ECHO    = 3'h7;
  typedef enum logic [1:0] {MODE_SLEEP, MODE_NORMAL, MODE_FAILSAFE} dev_mode_t;
endpackage

// *** sync_edge.sv ***
// Two-flop synchroniser with edge detection
module sync_edge #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic async_in,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic meta_q, sync_q, prev_q;
  logic meta_d, sync_d, prev_d;

  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      // Start at the pin's idle level so release of reset shows no edge
      meta_q <= IDLE_LEVEL;
      sync_q <= IDLE_LEVEL;
      prev_q <= IDLE_LEVEL;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;
  assign fall  = ~sync_q & prev_q;
endmodule

// *** switch_port_checker_sva.sv ***
// Port checker for the switch control serial port
module switch_port_checker
  import switch_ctrl_pkg::*;
(
  input wire logic                  clk,
  input wire logic                  reset_n,
  input wire logic                  sclk,
  input wire logic                  chip_select_n,
  input wire logic                  serial_out,
  input wire logic                  serial_out_oe_n,
  input wire logic                  wake_reset_n,
  input wire logic [1:0]            direct_in,
  input wire logic [1:0]            load_profile_select,
  input wire logic                  logic_supply_ok,
  input wire logic [FAULT_BITS-1:0] fault_events,
  input wire logic [1:0]            channel_on,
  input wire logic [1:0]            motor_profile,
  input wire logic                  fault_flag_n,
  input wire logic                  failsafe_flag_n,
  input wire logic                  sense_sync_n,
  input wire logic                  device_awake
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ----
  // Port relations
  // ----
  // Windows leave room for the 2-3 cycle input synchronisers
  a_oe_idle: assert property (chip_select_n [*5] |-> serial_out_oe_n)
    else $error("serial out driven while deselected");
  a_so_hold: assert property ((!sclk && !chip_select_n) [*6] |-> $stable(serial_out))
    else $error("serial out moved without a clock rise");
  a_fault_flag: assert property (|(fault_events & 9'h1BF) |-> ##[1:4] !fault_flag_n)
    else $error("fault flag missed a live fault");
  a_sense_rise: assert property ($fell(channel_on[0]) |-> ##[0:2] sense_sync_n)
    else $error("sync not high at turn off");
  a_profile_follow: assert property (
    $stable(load_profile_select) [*6] |-> motor_profile == load_profile_select)
    else $error("profile output differs from select");
  a_direct_ctrl: assert property (
    (!wake_reset_n && fault_events == '0 && $stable(direct_in)) [*6] |-> channel_on == direct_in)
    else $error("channel differs from direct input");
  a_wake_direct: assert property ($rose(direct_in[0]) |-> ##[1:5] device_awake)
    else $error("direct input rise did not wake");
  a_supply_fs: assert property ((wake_reset_n && !logic_supply_ok) [*5] |-> !failsafe_flag_n)
    else $error("fail-safe flag missed supply loss");
  a_nosupply_hiz: assert property ((chip_select_n && !logic_supply_ok) ##1 (!logic_supply_ok) [*5] |-> serial_out_oe_n)
    else $error("serial out driven without logic supply");
endmodule

bind switch_control_serial_port switch_port_checker chk (
  .clk, .reset_n, .sclk, .chip_select_n, .serial_out, .serial_out_oe_n, .wake_reset_n, .direct_in,
  .load_profile_select, .logic_supply_ok, .fault_events, .channel_on, .motor_profile, .fault_flag_n,
  .failsafe_flag_n, .sense_sync_n, .device_awake);

// *** host_spi_model.sv ***
// Host serial master model for the switch port
module host_spi_model (
  input  wire logic clk,
  input  wire logic so,
  output logic      sclk,
  output logic      chip_select_n,
  output logic      serial_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wd_q = 1'h1;
  initial begin
    sclk = 1'h0;
    chip_select_n = 1'h1;
    serial_in = 1'h0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  // Half period of 4 cycles gives the 400 ns serial clock
  task automatic xfer(inout logic [15:0] tx, output logic [15:0] rx);
    tx[15] = wd_q;
    wd_q = ~wd_q;
    chip_select_n = 1'h0;
    step(10);
    for (int i = 15; i >= 0; i--) begin
      serial_in = tx[i];
      sclk = 1'h1;
      step(4);
      sclk = 1'h0;
      rx[i] = so;
      step(4);
    end
    chip_select_n = 1'h1;
    serial_in = 1'h0;
    step(24);
  endtask
endmodule

// *** switch_control_serial_port_tb.sv ***
// Self-checking bench for the switch control serial port
module switch_control_serial_port_tb;
  import switch_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TMO = 100;
  localparam int WDT = 2000;
  logic                  clk = 1'h0;
  logic                  reset_n = 1'h0;
  logic                  wake_reset_n = 1'h0;
  logic                  pwm_clock_in = 1'h0;
  logic                  pwm_run = 1'h0;
  logic                  logic_supply_ok = 1'h1;
  logic [1:0]            direct_in = 2'h0;
  logic [1:0]            load_profile_select = 2'h3;
  logic [1:0]            sense_valid = 2'h0;
  logic [FAULT_BITS-1:0] fault_events = '0;
  logic                  sclk, chip_select_n, serial_in, serial_out, serial_out_oe_n;
  logic                  fault_flag_n, failsafe_flag_n, sense_sync_n, device_awake;
  logic [1:0]            channel_on, motor_profile;
  logic [15:0]           tx, rx;
  logic [15:0]           sent[$];
  int                    failures = 0;
  int                    n_tests = 0;
  int                    seed = 40901;
  int                    cycles = 0;
  always #25 clk = ~clk;
  always begin
    repeat (20) @(posedge clk);
    #2;
    if (pwm_run) pwm_clock_in = ~pwm_clock_in;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 12000) begin
      failures++;
      tally_and_finish();
    end
  end
  switch_control_serial_port #(.WDT_COUNT(WDT), .IN_TIMEOUT(TMO), .CLK_LOSS(64), .PWM_DIV(10)) uut (
    .clk, .reset_n, .sclk, .chip_select_n, .serial_in, .serial_out, .serial_out_oe_n, .wake_reset_n,
    .direct_in, .load_profile_select, .pwm_clock_in, .logic_supply_ok, .fault_events, .sense_valid,
    .channel_on, .motor_profile, .fault_flag_n, .failsafe_flag_n, .sense_sync_n, .device_awake);
  host_spi_model host (.clk, .so(serial_out ^ serial_out_oe_n), .sclk, .chip_select_n, .serial_in);
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk_frame(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [1:0] e, input logic [1:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----
  // Main sequence
  // ----
  initial begin
    step(3);
    reset_n = 1'h1;
    step(TMO + 20);
    chk_pin("awake", 2'h0, {1'h0, device_awake});
    sense_valid = 2'h3;
    direct_in = 2'h1;
    step(8);
    chk_pin("awake", 2'h1, {1'h0, device_awake});
    chk_pin("channels", 2'h1, channel_on);
    chk_pin("sync", 2'h0, {1'h0, sense_sync_n});
    direct_in = 2'h2;
    step(8);
    chk_pin("channels", 2'h2, channel_on);
    direct_in = 2'h0;
    step(8);
    chk_pin("sync", 2'h1, {1'h0, sense_sync_n});
    step(TMO + 20);
    chk_pin("awake", 2'h0, {1'h0, device_awake});
    wake_reset_n = 1'h1;
    for (int i = 0; i < 4; i++) begin
      load_profile_select = 2'(i);
      step(8);
      chk_pin("profile", 2'(i), motor_profile);
    end
    chk_pin("awake", 2'h1, {1'h0, device_awake});
    step(100);
    // Address low bits 7 select the echo of the previous frame
    for (int i = 0; i < 6; i++) begin
      tx = 16'($random(seed)) | 16'h0E00;
      host.xfer(tx, rx);
      if (sent.size() > 0)
        chk_frame("echo", sent.pop_front(), rx);
      sent.push_back(tx);
    end
    tx = 16'h0000;
    host.xfer(tx, rx);
    for (int k = 0; k < FAULT_BITS; k++) begin
      if (k != 6) begin
        fault_events = FAULT_BITS'(1 << k);
        step(3);
        fault_events = '0;
        step(4);
        chk_pin("fault_flag", 2'h0, {1'h0, fault_flag_n});
        tx = 16'h0000;
        host.xfer(tx, rx);
        chk_frame("status", 16'(1 << k), {7'h0, rx[8:0]});
        chk_pin("fault_flag", 2'h1, {1'h0, fault_flag_n});
      end
    end
    pwm_run = 1'h1;
    tx = 16'h0201;
    host.xfer(tx, rx);
    step(100);
    chk_pin("clock_fault", 2'h1, {1'h0, fault_flag_n});
    pwm_run = 1'h0;
    step(100);
    chk_pin("clock_fault", 2'h0, {1'h0, fault_flag_n});
    chk_pin("failsafe", 2'h1, {1'h0, failsafe_flag_n});
    logic_supply_ok = 1'h0;
    step(8);
    chk_pin("failsafe", 2'h0, {1'h0, failsafe_flag_n});
    tx = 16'h0000;
    host.xfer(tx, rx);
    logic_supply_ok = 1'h1;
    // Wake pulse leaves fail-safe so the watchdog expiry below stands alone
    wake_reset_n = 1'h0;
    step(4);
    wake_reset_n = 1'h1;
    step(8);
    chk_pin("failsafe", 2'h1, {1'h0, failsafe_flag_n});
    step(WDT + 50);
    chk_pin("failsafe", 2'h0, {1'h0, failsafe_flag_n});
    tally_and_finish();
  end
endmodule
